// >>> logic/lls_link_status.sv
// Lane link status bank: error counters, status bytes, irq, Wishbone slave
`timescale 1ns/1ps
`default_nettype none
`include "lls_map.svh"

// Notes on behaviour
// - Bit 7 flags lane bad-disparity count at or above shared threshold.
// - Bit 6 flags lane not-in-table count at or above threshold.
// - Bit 5 flags lane unexpected control character count at or above threshold.
// - Error flags read 0 below threshold, 1 when count equals or exceeds it.
// - Bit 4 is 1 when interlane deskew achieved, 0 when failed.
// - Bit 3 is 1 while initial lane sync holds, 0 once lost.
// - Bit 2 is 1 when lane configuration checksum matches, else 0.
// - Bit 1 is 1 while frame sync holds, 0 after loss.
// - Bit 0 follows code group sync, valid whether alignment skipped or not.
// - All status flags are read-only and are 0 after reset.
// - One status byte per lane at consecutive indices, lane 2, lane 3 then lane 4.
module lls_link_status
  import lls_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire logic                  reset_n,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [`LLS_ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  output logic                       irq_o,
  output logic                       skip_alignment_sequence,
  input  wire logic [2:0]            disparity_err_evt,
  input  wire logic [2:0]            not_in_table_err_evt,
  input  wire logic [2:0]            unexpected_char_err_evt,
  input  wire logic [2:0]            interlane_deskew_done,
  input  wire logic [2:0]            initial_lane_sync_status,
  input  wire logic [2:0]            lane_sum_match_status,
  input  wire logic [2:0]            frame_sync_status,
  input  wire logic [2:0]            code_group_sync_status
);

  localparam int NL = `LLS_NUM_LANES;
  localparam int IW = `LLS_IRQ_W;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic lls_cnt_t cnt_step(
    input lls_cnt_t c,
    input logic     ev,
    input logic     clr
  );
    lls_cnt_t n;
    n = c;
    if (clr) begin
      n = '0;
    end else if (ev && (c != `LLS_CNT_MAX)) begin
      n = lls_cnt_t'(c + 8'h01);
    end
    return n;
  endfunction : cnt_step

  function automatic lls_idx_t lane_idx(input int lane);
    return lls_idx_t'(`LLS_IDX_LANE2 + lane);
  endfunction : lane_idx

  function automatic lls_idx_t word_idx(input logic [`LLS_ADR_W-1:0] a);
    return a[`LLS_ADR_W-1:`LLS_ADR_LSB];
  endfunction : word_idx

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  lls_cnt_t  disp_cnt_r [NL];
  lls_cnt_t  notab_cnt_r [NL];
  lls_cnt_t  unexp_cnt_r [NL];
  lls_byte_t status_r   [NL];
  lls_byte_t thresh_r;
  logic      skip_r;
  logic      ack_r;
  lls_word_t dat_r;
  lls_word_t rd_nxt;
  logic [IW-1:0] irq_stat_r;
  logic [IW-1:0] irq_mask_r;
  logic [IW-1:0] irq_evt;
  logic [IW-1:0] irq_clr;
  logic [NL-1:0] err_now;
  logic [NL-1:0] err_prev;
  logic [NL-1:0] code_loss;
  logic          bus_req;
  logic          wr_fire;
  logic          wr_lo;
  logic          cnt_clr;
  lls_idx_t      bus_idx;

  ////////////////////////////////////////////////////////////////////////
  // Bus decode

  assign bus_req = wb_cyc_i & wb_stb_i;
  assign bus_idx = word_idx(wb_adr_i);
  // Writes commit on the edge where the master sees ack
  assign wr_fire = bus_req & wb_we_i & ack_r;
  assign wr_lo   = wr_fire & wb_sel_i[0];
  assign cnt_clr = wr_lo & (bus_idx == `LLS_IDX_CTRL)
                 & wb_dat_i[`LLS_CTRL_CLR];

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= bus_req & ~ack_r;
    end
  end

  always_comb begin
    rd_nxt = '0;
    for (int i = 0; i < NL; i++) begin
      if (bus_idx == lane_idx(i)) begin
        rd_nxt[7:0] = status_r[i];
      end
    end
    case (bus_idx)
      `LLS_IDX_THRESH: begin
        rd_nxt[7:0] = thresh_r;
      end
      `LLS_IDX_CTRL: begin
        rd_nxt[`LLS_CTRL_SKIP] = skip_r;
      end
      `LLS_IDX_IRQ_STAT: begin
        rd_nxt[IW-1:0] = irq_stat_r;
      end
      `LLS_IDX_IRQ_MASK: begin
        rd_nxt[IW-1:0] = irq_mask_r;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      dat_r <= '0;
    end else if (bus_req && !ack_r && !wb_we_i) begin
      dat_r <= rd_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  ////////////////////////////////////////////////////////////////////////
  // Control registers

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      thresh_r <= `LLS_THR_RST;
    end else if (wr_lo && (bus_idx == `LLS_IDX_THRESH)) begin
      thresh_r <= wb_dat_i[7:0];
    end
  end

  // Status bytes are read-only: no write path reaches them
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      skip_r <= 1'b0;
    end else if (wr_lo && (bus_idx == `LLS_IDX_CTRL)) begin
      skip_r <= wb_dat_i[`LLS_CTRL_SKIP];
    end
  end

  // Receiver is told to skip alignment; software must then ignore bits 4..1
  assign skip_alignment_sequence = skip_r;

  ////////////////////////////////////////////////////////////////////////
  // Per-lane error counters, saturating

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NL; i++) begin
        disp_cnt_r[i]  <= '0;
        notab_cnt_r[i] <= '0;
        unexp_cnt_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NL; i++) begin
        disp_cnt_r[i]  <= cnt_step(disp_cnt_r[i], disparity_err_evt[i], cnt_clr);
        notab_cnt_r[i] <= cnt_step(notab_cnt_r[i], not_in_table_err_evt[i], cnt_clr);
        unexp_cnt_r[i] <= cnt_step(unexp_cnt_r[i], unexpected_char_err_evt[i], cnt_clr);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status bytes

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NL; i++) begin
        status_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NL; i++) begin
        status_r[i][`LLS_BIT_DISP]   <= disp_cnt_r[i] >= thresh_r;
        status_r[i][`LLS_BIT_NOTAB]  <= notab_cnt_r[i] >= thresh_r;
        status_r[i][`LLS_BIT_UNEXP]  <= unexp_cnt_r[i] >= thresh_r;
        status_r[i][`LLS_BIT_DESKEW] <= interlane_deskew_done[i];
        status_r[i][`LLS_BIT_LSYNC]  <= initial_lane_sync_status[i];
        status_r[i][`LLS_BIT_SUM]    <= lane_sum_match_status[i];
        status_r[i][`LLS_BIT_FRAME]  <= frame_sync_status[i];
        status_r[i][`LLS_BIT_CODE]   <= code_group_sync_status[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupts

  always_comb begin
    for (int i = 0; i < NL; i++) begin
      err_now[i]   = (disp_cnt_r[i] >= thresh_r) | (notab_cnt_r[i] >= thresh_r)
                   | (unexp_cnt_r[i] >= thresh_r);
      err_prev[i]  = |status_r[i][`LLS_BIT_DISP:`LLS_BIT_UNEXP];
      code_loss[i] = status_r[i][`LLS_BIT_CODE] & ~code_group_sync_status[i];
    end
  end

  always_comb begin
    irq_evt = '0;
    irq_evt[`LLS_IRQ_ERR_LSB +: NL] = err_now & ~err_prev;
    irq_evt[`LLS_IRQ_CODE_LSB +: NL] = code_loss;
    irq_clr = '0;
    if (wr_lo && (bus_idx == `LLS_IDX_IRQ_STAT)) begin
      irq_clr = wb_dat_i[IW-1:0];
    end
  end

  // A new event wins over a clear in the same cycle
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_evt;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_mask_r <= '0;
    end else if (wr_lo && (bus_idx == `LLS_IDX_IRQ_MASK)) begin
      irq_mask_r <= wb_dat_i[IW-1:0];
    end
  end

  assign irq_o = |(irq_stat_r & irq_mask_r);

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  for (genvar g = 0; g < NL; g++) begin : g_chk
    disp_at_thresh_a: assert property (
      (disp_cnt_r[g] >= thresh_r) |=> status_r[g][`LLS_BIT_DISP])
      else $error("disparity flag missing at threshold");

    notab_below_thresh_a: assert property (
      (notab_cnt_r[g] < thresh_r) |=> !status_r[g][`LLS_BIT_NOTAB])
      else $error("not-in-table flag set below threshold");

    unexp_flag_a: assert property (
      (unexp_cnt_r[g] >= thresh_r) |=> status_r[g][`LLS_BIT_UNEXP])
      else $error("unexpected character flag missing");

    flag_equal_a: assert property (
      (disp_cnt_r[g] == thresh_r) && !cnt_clr
      && !(wr_lo && (bus_idx == `LLS_IDX_THRESH))
      |=> status_r[g][`LLS_BIT_DISP] ##1 status_r[g][`LLS_BIT_DISP])
      else $error("flag clear at equal count");

    deskew_follow_a: assert property (
      $fell(interlane_deskew_done[g]) |=> !status_r[g][`LLS_BIT_DESKEW])
      else $error("deskew flag did not drop");

    lsync_follow_a: assert property (
      $rose(initial_lane_sync_status[g]) |=> status_r[g][`LLS_BIT_LSYNC])
      else $error("lane sync flag did not rise");

    sum_follow_a: assert property (
      lane_sum_match_status[g] |=> status_r[g][`LLS_BIT_SUM])
      else $error("checksum flag wrong");

    frame_follow_a: assert property (
      !frame_sync_status[g] |=> !status_r[g][`LLS_BIT_FRAME])
      else $error("frame sync flag wrong");

    code_skip_a: assert property (
      skip_r && code_group_sync_status[g] |=> status_r[g][`LLS_BIT_CODE])
      else $error("code group flag lost under skip");

    reset_zero_a: assert property (
      !$past(reset_n) |-> (status_r[g] == 8'h00))
      else $error("status not zero after reset");

    lane_read_a: assert property (
      bus_req && !wb_we_i && !ack_r && (bus_idx == lane_idx(g))
      |=> wb_ack_o && (wb_dat_o[7:0] == $past(status_r[g])))
      else $error("lane status read mismatch");

    cnt_inc_a: assert property (
      disparity_err_evt[g] && !cnt_clr && (disp_cnt_r[g] != `LLS_CNT_MAX)
      |=> disp_cnt_r[g] == lls_cnt_t'($past(disp_cnt_r[g]) + 8'h01))
      else $error("disparity counter did not count");

    unexp_inc_a: assert property (
      unexpected_char_err_evt[g] && !cnt_clr && (unexp_cnt_r[g] != `LLS_CNT_MAX)
      |=> unexp_cnt_r[g] == lls_cnt_t'($past(unexp_cnt_r[g]) + 8'h01))
      else $error("unexpected character counter did not count");

    cnt_clear_a: assert property (
      cnt_clr |=> (disp_cnt_r[g] == '0) && (notab_cnt_r[g] == '0)
                  && (unexp_cnt_r[g] == '0))
      else $error("error counters not cleared");
  end

  // Sticky status: an event always lands, a clear only without one
  for (genvar b = 0; b < IW; b++) begin : g_irq
    irq_set_wins_a: assert property (
      irq_evt[b] |=> irq_stat_r[b])
      else $error("interrupt event lost");

    irq_clear_a: assert property (
      irq_clr[b] && !irq_evt[b] |=> !irq_stat_r[b])
      else $error("interrupt bit not cleared");
  end

endmodule : lls_link_status

`default_nettype wire

// >>> logic/lls_map.svh
// Offsets, field positions and reset values of the lane link status bank
`ifndef LLS_MAP_SVH
`define LLS_MAP_SVH

`define LLS_NUM_LANES     3
`define LLS_IDX_LANE2     11'h4B2
`define LLS_IDX_LANE3     11'h4B3
`define LLS_IDX_LANE4     11'h4B4
`define LLS_IDX_THRESH    11'h4C0
`define LLS_IDX_CTRL      11'h4C1
`define LLS_IDX_IRQ_STAT  11'h4C2
`define LLS_IDX_IRQ_MASK  11'h4C3

`define LLS_BIT_DISP      7
`define LLS_BIT_NOTAB     6
`define LLS_BIT_UNEXP     5
`define LLS_BIT_DESKEW    4
`define LLS_BIT_LSYNC     3
`define LLS_BIT_SUM       2
`define LLS_BIT_FRAME     1
`define LLS_BIT_CODE      0

`define LLS_CTRL_SKIP     0
`define LLS_CTRL_CLR      1
`define LLS_IRQ_W         6
`define LLS_IRQ_ERR_LSB   0
`define LLS_IRQ_CODE_LSB  3

`define LLS_THR_RST       8'hFF
`define LLS_CNT_MAX       8'hFF
`define LLS_ADR_W         13
`define LLS_ADR_LSB       2

`endif

// >>> logic/lls_pkg.sv
// Types shared by the lane link status bank
`default_nettype none

package lls_pkg;
  typedef logic [7:0]  lls_byte_t;
  typedef logic [7:0]  lls_cnt_t;
  typedef logic [10:0] lls_idx_t;
  typedef logic [31:0] lls_word_t;
endpackage : lls_pkg

`default_nettype wire

// >>> sim/lls_link_status_tb.sv
// Self-checking bench for the lane link status bank
`timescale 1ns/1ps
`default_nettype none
`include "lls_map.svh"
module lls_link_status_tb;
  import lls_pkg::*;
  logic        ref_clk     = 1'b0;
  logic        reset_n     = 1'b0;
  logic        cyc         = 1'b0;
  logic        stb         = 1'b0;
  logic        we          = 1'b0;
  logic [12:0] adr         = '0;
  lls_word_t   dat         = '0;
  lls_word_t   dout;
  lls_word_t   rdat;
  logic        ack;
  logic        irq;
  logic        skip;
  logic [2:0]  ev [3];
  logic [2:0]  lv [5];
  int          cnt [3][3];
  int          thr;
  int          err_total   = 0;
  int          checks_done = 0;

  always #2.5 ref_clk = ~ref_clk;

  lls_link_status lls_link_status_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack),
    .irq_o(irq), .skip_alignment_sequence(skip), .disparity_err_evt(ev[0]),
    .not_in_table_err_evt(ev[1]), .unexpected_char_err_evt(ev[2]),
    .interlane_deskew_done(lv[0]), .initial_lane_sync_status(lv[1]),
    .lane_sum_match_status(lv[2]), .frame_sync_status(lv[3]), .code_group_sync_status(lv[4])
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input lls_word_t seen, input lls_word_t exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wb(input logic w, input lls_idx_t idx, input lls_word_t d);
    int n;
    n = 0;
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {idx, 2'b00};
    dat <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      err_total++;
      $display("unexpected %0t: no bus answer", $time);
    end
    rdat = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge ref_clk);
  endtask : wb

  task automatic rd_chk(input lls_idx_t idx, input lls_word_t e);
    wb(1'b0, idx, '0);
    check(rdat, e);
  endtask : rd_chk

  // Model of one lane status byte
  function automatic lls_byte_t exp_st(int l);
    lls_byte_t b;
    for (int t = 0; t < 3; t++)
      b[7-t] = (cnt[t][l] >= thr);
    for (int k = 0; k < 5; k++)
      b[4-k] = lv[k][l];
    return b;
  endfunction : exp_st

  task automatic chk_lanes;
    for (int l = 0; l < 3; l++)
      rd_chk(lls_idx_t'(`LLS_IDX_LANE2 + l), {24'h0, exp_st(l)});
  endtask : chk_lanes

  task automatic clr;
    wb(1'b1, `LLS_IDX_CTRL, 32'h0000_0002);
    cnt = '{default: 0};
  endtask : clr

  // Random lane levels and error bursts, then compare every lane
  task automatic round(input int th, input int n);
    logic [8:0] r;
    wb(1'b1, `LLS_IDX_THRESH, lls_word_t'(th));
    thr = th;
    for (int k = 0; k < 5; k++)
      lv[k] <= 3'($urandom);
    for (int i = 0; i < n; i++) begin
      r = 9'($urandom);
      for (int t = 0; t < 3; t++) begin
        ev[t] <= r[3*t +: 3];
        for (int l = 0; l < 3; l++)
          if (r[3*t+l] && cnt[t][l] < 255)
            cnt[t][l]++;
      end
      @(posedge ref_clk);
    end
    for (int t = 0; t < 3; t++)
      ev[t] <= 3'h0;
    repeat (3) @(posedge ref_clk);
    chk_lanes();
  endtask : round

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #60000;
    err_total++;
    conclude();
  end

  initial begin
    void'($urandom(32'h41BB8296));
    for (int t = 0; t < 3; t++)
      ev[t] = 3'h0;
    for (int k = 0; k < 5; k++)
      lv[k] = 3'h0;
    cnt = '{default: 0};
    thr = 255;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    chk_lanes();
    rd_chk(`LLS_IDX_THRESH, 32'h0000_00FF);
    wb(1'b1, `LLS_IDX_LANE3, 32'h0000_00FF);
    rd_chk(`LLS_IDX_LANE3, 32'h0);
    rd_chk(11'h4B1, 32'h0);
    round(4, 6);
    round(4, 10);
    clr();
    round(1, 1);
    round(0, 0);
    clr();
    round(255, 3);
    // Skip set: code group flag still tracked
    wb(1'b1, `LLS_IDX_CTRL, 32'h0000_0001);
    check(32'(skip), 32'h1);
    round(3, 5);
    wb(1'b1, `LLS_IDX_CTRL, 32'h0);
    // Sticky event, mask, write-one-to-clear
    clr();
    wb(1'b1, `LLS_IDX_IRQ_STAT, 32'h0000_003F);
    wb(1'b1, `LLS_IDX_THRESH, 32'h0000_0001);
    thr = 1;
    ev[0] <= 3'h2;
    @(posedge ref_clk);
    ev[0] <= 3'h0;
    cnt[0][1] = 1;
    repeat (3) @(posedge ref_clk);
    rd_chk(`LLS_IDX_IRQ_STAT, 32'h0000_0002);
    #1 check(32'(irq), 32'h0);
    wb(1'b1, `LLS_IDX_IRQ_MASK, 32'h0000_0002);
    #1 check(32'(irq), 32'h1);
    wb(1'b1, `LLS_IDX_IRQ_STAT, 32'h0000_0002);
    rd_chk(`LLS_IDX_IRQ_STAT, 32'h0);
    #1 check(32'(irq), 32'h0);
    // Code group sync loss on lane 3 sets its sticky bit
    @(posedge ref_clk);
    lv[4] <= 3'h7;
    repeat (2) @(posedge ref_clk);
    wb(1'b1, `LLS_IDX_IRQ_STAT, 32'h0000_003F);
    lv[4] <= 3'h5;
    repeat (2) @(posedge ref_clk);
    rd_chk(`LLS_IDX_IRQ_STAT, 32'h0000_0010);
    #1 check(32'(irq), 32'h0);
    chk_lanes();
    conclude();
  end
endmodule : lls_link_status_tb
`default_nettype wire
